// File: src/xfer_init_regs.svh
// Constants for the read transfer start-up block: decode codes, field positions, delays
`ifndef XFER_INIT_REGS_SVH
`define XFER_INIT_REGS_SVH

// ----------------------------------------------------------------
// Device decode (select lines 3..9 carry address bits 8..2)
// ----------------------------------------------------------------
`define DEV_ADDR       9'h0b8
`define REG_SEL_CTRL   4'h8
`define FUNC_READ      5'h1c

// ----------------------------------------------------------------
// I/O data fields, bit 00 is the MSB at index 35
// ----------------------------------------------------------------
`define IOB_RSEL       35:32
`define IOB_DRIVE      20:18
`define IOB_ADDR       14:7
`define IOB_FUNC       5:1
`define IOB_GO         0
`define CHB_ADDR       8:1

// ----------------------------------------------------------------
// Timing, in ns, and derived cycle counts at the system clock
// ----------------------------------------------------------------
`define CLK_NS         10
`define T_REQ_NS       50
`define T_DEVPLS_NS    100
`define T_CYCACT_NS    100
`define T_DESKEW_NS    275
`define T_DEMAND_NS    1500
`define CYC_MIN(ns)    (((ns) + `CLK_NS - 1) / `CLK_NS)
`define CYC_MAX(ns)    ((ns) / `CLK_NS)

`endif

// File: src/xfer_init_pkg.sv
// Types shared by the read transfer start-up block
package xfer_init_pkg;

  // ----------------------------------------------------------------
  // Channel side signals
  // ----------------------------------------------------------------
  typedef struct packed {
    logic grant;      // channel_grant_in
    logic start_req;  // channel_start_request_in from down the chain
    logic pulse;      // channel pulse with a word
  } chan_in_s;

  typedef struct packed {
    logic        start_req;   // channel_start_request_out
    logic        grant_down;  // grant passed down the chain
    logic        device_pulse;
    logic        data_strobe;
    logic        direction;   // transfer_direction_out, 1 = drive to memory
    logic [35:0] bus;         // channel bus drivers
  } chan_out_s;

  // ----------------------------------------------------------------
  // Drive control bus
  // ----------------------------------------------------------------
  typedef struct packed {
    logic demand;
    logic cycle_active;
    logic cycle_sync;
  } drive_out_s;

endpackage

// File: src/pulse_delay.sv
// Retriggerable delay: one-cycle fire pulse a fixed count after start
`timescale 1ns/1ps
`default_nettype none
module pulse_delay #(
  parameter int CYCLES = 1
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  input  wire logic cancel_i,
  output logic      run_o,
  output logic      fire_o
);
  localparam logic [7:0] LAST = 8'(CYCLES - 1);

  logic [7:0] cnt_ff;
  logic       run_ff;
  logic [7:0] nxt_cnt;
  logic       nxt_run;
  wire        at_end = run_ff && (cnt_ff == LAST);

  // ----------------------------------------------------------------
  // Counter; start restarts, cancel wins over expiry
  // ----------------------------------------------------------------
  assign nxt_run = start_i || (run_ff && !at_end && !cancel_i);
  assign nxt_cnt = start_i ? 8'h00 : (run_ff ? cnt_ff + 8'h01 : cnt_ff);
  assign fire_o  = at_end && !cancel_i && !start_i;
  assign run_o   = run_ff;

  // State update
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= 8'h00;
      run_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
    end
  end
endmodule
`default_nettype wire

// File: src/read_transfer_initiation.sv
// Read transfer start-up: command decode, channel arbitration, first control cycle
`timescale 1ns/1ps
`default_nettype none
`include "xfer_init_regs.svh"
module read_transfer_initiation (
  input  wire logic                    sys_clk_i,
  input  wire logic                    rst_i,
  // CPU I/O bus, same clock domain
  input  wire logic                    data_out_instruction_i,
  input  wire logic [6:0]              io_select_lines_i,
  input  wire logic [35:0]             io_data_bits_i,
  input  wire logic                    transfer_complete_i,
  // Controller state and mode inputs, same clock domain
  input  wire logic                    prior_start_pending_i,
  input  wire logic                    local_mode_i,
  input  wire logic                    bootstrap_read_mode_i,
  input  wire logic                    maint_mode_i,
  input  wire logic                    register_bus_cycle_req_i,
  input  wire logic                    prev_cycle_read_i,
  input  wire logic                    attn_summary_addressed_i,
  // Pins from the panel, channel and drive
  input  wire logic                    panel_channel_switch_i,
  input  wire xfer_init_pkg::chan_in_s chan_i,
  input  wire logic                    transfer_ack_signal_i,
  // Outputs
  output xfer_init_pkg::chan_out_s     chan_o,
  output xfer_init_pkg::drive_out_s    drive_o,
  output logic [2:0]                   drive_choice_o,
  output logic [4:0]                   function_code_o,
  output logic                         go_o,
  output logic                         initial_clear_pulse_o,
  output logic                         controller_busy_flag_o,
  output logic                         completion_flag_o,
  output logic                         channel_buffer_full_o,
  output logic                         channel_pulse_seen_o,
  output logic                         register_bus_cycle_flag_o,
  output logic                         drive_response_error_o
);

  // ----------------------------------------------------------------
  // Pin synchronisers: two flops before any logic looks
  // ----------------------------------------------------------------
  logic [4:0] pin_meta_ff;
  logic [4:0] pin_sync_ff;
  wire  [4:0] pin_raw = {panel_channel_switch_i, chan_i.grant, chan_i.start_req,
                         chan_i.pulse, transfer_ack_signal_i};

  // Metastability stage feeds only the second stage
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta_ff <= 5'h00;
      pin_sync_ff <= 5'h00;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  wire panel_sw  = pin_sync_ff[4];
  wire grant_in  = pin_sync_ff[3];
  wire start_in  = pin_sync_ff[2];
  wire cpulse_in = pin_sync_ff[1];
  wire tra_in    = pin_sync_ff[0];

  // ----------------------------------------------------------------
  // Command decode and register select
  // ----------------------------------------------------------------
  logic [3:0]  register_select_latch_ff;
  logic        data_out_decoded_ff;
  logic [35:0] io_hold_ff;

  localparam logic [8:0] DEV_ADDR_FULL = `DEV_ADDR;
  wire dev_hit  = io_select_lines_i == DEV_ADDR_FULL[8:2];
  wire dout_hit = data_out_instruction_i && dev_hit;
  wire control_register_selected = register_select_latch_ff == `REG_SEL_CTRL;

  // Latch select and data on a decoded data-out; strobe comes a cycle later
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      register_select_latch_ff <= 4'h0;
      data_out_decoded_ff      <= 1'b0;
      io_hold_ff               <= 36'h0;
    end else begin
      data_out_decoded_ff <= dout_hit;
      if (dout_hit) begin
        register_select_latch_ff <= io_data_bits_i[`IOB_RSEL];
        io_hold_ff               <= io_data_bits_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control register load strobe, two copies for fan-out
  // ----------------------------------------------------------------
  wire control_load_strobe_a = transfer_complete_i && control_register_selected
                               && data_out_decoded_ff;
  wire control_load_strobe_b = transfer_complete_i && control_register_selected
                               && data_out_decoded_ff;
  wire initial_clear = control_load_strobe_a;

  logic [2:0] drive_choice_ff;
  logic [7:0] initial_address_register_ff;
  logic [4:0] function_code_register_ff;
  logic       go_ff;
  logic       strobe_d_ff;

  // Field capture from the held command word
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      drive_choice_ff             <= 3'h0;
      initial_address_register_ff <= 8'h00;
      function_code_register_ff   <= 5'h00;
      go_ff                       <= 1'b0;
      strobe_d_ff                 <= 1'b0;
    end else begin
      strobe_d_ff <= control_load_strobe_b;
      if (control_load_strobe_a) begin
        drive_choice_ff             <= io_hold_ff[`IOB_DRIVE];
        initial_address_register_ff <= io_hold_ff[`IOB_ADDR];
      end
      if (control_load_strobe_b) begin
        function_code_register_ff   <= io_hold_ff[`IOB_FUNC];
        go_ff                       <= io_hold_ff[`IOB_GO];
      end
    end
  end

  // Trailing edge of the strobe, gated by go
  wire start_transfer_pulse = strobe_d_ff && !control_load_strobe_b && go_ff;
  wire is_read = function_code_register_ff == `FUNC_READ;

  // ----------------------------------------------------------------
  // Busy / done and channel arbitration flags
  // ----------------------------------------------------------------
  logic busy_ff;
  logic done_ff;
  logic req_buf_ff;
  logic req_active_ff;
  logic claimed_ff;
  logic owned_d_ff;

  wire channel_start_permit = !local_mode_i || panel_sw;
  wire channel_owned = grant_in && req_active_ff;
  wire owned_rise    = channel_owned && !owned_d_ff;
  wire req_timer_fire;

  // Busy set, or refused into done when a previous start is pending
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (start_transfer_pulse) begin
      busy_ff <= !prior_start_pending_i;
      done_ff <= prior_start_pending_i;
    end else if (initial_clear) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end
  end

  // Request buffer: start sets it, ownership clears it; set wins
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_buf_ff <= 1'b0;
    end else if (start_transfer_pulse && channel_start_permit) begin
      req_buf_ff <= 1'b1;
    end else if (owned_rise || initial_clear) begin
      req_buf_ff <= 1'b0;
    end
  end

  // 50 ns settle before the request goes active
  pulse_delay #(.CYCLES(`CYC_MIN(`T_REQ_NS))) req_dly (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .start_i   (start_transfer_pulse && channel_start_permit),
    .cancel_i  (initial_clear),
    .run_o     (),
    .fire_o    (req_timer_fire)
  );

  // Downstream request claims the channel and locks out our own
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_active_ff <= 1'b0;
      claimed_ff    <= 1'b0;
      owned_d_ff    <= 1'b0;
    end else begin
      owned_d_ff <= channel_owned;
      if (req_timer_fire && req_buf_ff && !claimed_ff && !start_in) begin
        req_active_ff <= 1'b1;
      end else if (initial_clear) begin
        req_active_ff <= 1'b0;
      end
      if (start_in && !req_active_ff) begin
        claimed_ff <= 1'b1;
      end else if (initial_clear || !start_in) begin
        claimed_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Initial address, device pulse and data strobe
  // ----------------------------------------------------------------
  logic addr_en_ff;
  logic data_strobe_ff;
  logic cb_full_ff;
  logic cpulse_ff;
  logic cpulse_seen_ff;
  logic cpulse_d_ff;
  logic [35:0] chan_bus_ff;
  wire  dev_pulse;

  // The seen flag stops the address path running a second time
  wire init_addr_strobe = owned_rise && busy_ff && !bootstrap_read_mode_i
                          && !cpulse_seen_ff;
  wire [35:0] mixer;
  assign mixer = addr_en_ff ? {27'h0, initial_address_register_ff, 1'b0} : 36'h0;
  wire strobe_fall = data_strobe_ff && dev_pulse;
  wire cpulse_rise = cpulse_in && !cpulse_d_ff;

  // 100 ns from the address strobe to the device pulse
  pulse_delay #(.CYCLES(`CYC_MIN(`T_DEVPLS_NS))) dev_dly (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .start_i   (init_addr_strobe),
    .cancel_i  (initial_clear),
    .run_o     (),
    .fire_o    (dev_pulse)
  );

  // Address enable and data strobe; strobe ends with the device pulse
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      addr_en_ff     <= 1'b0;
      data_strobe_ff <= 1'b0;
      chan_bus_ff    <= 36'h0;
    end else begin
      if (init_addr_strobe) begin
        addr_en_ff <= 1'b1;
      end else if (strobe_fall || initial_clear) begin
        addr_en_ff <= 1'b0;
      end
      if (init_addr_strobe) begin
        data_strobe_ff <= 1'b1;
      end else if (dev_pulse || initial_clear) begin
        data_strobe_ff <= 1'b0;
      end
      if (data_strobe_ff) begin
        chan_bus_ff <= mixer;
      end
    end
  end

  // Word arrival fills the buffer; the data strobe empties it
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cb_full_ff     <= 1'b0;
      cpulse_ff      <= 1'b0;
      cpulse_seen_ff <= 1'b0;
      cpulse_d_ff    <= 1'b0;
    end else begin
      cpulse_d_ff <= cpulse_in;
      if (cpulse_rise) begin
        cb_full_ff <= 1'b1;
      end else if (data_strobe_ff || initial_clear) begin
        cb_full_ff <= 1'b0;
      end
      if (cpulse_rise) begin
        cpulse_ff <= 1'b1;
      end else if (dev_pulse || initial_clear) begin
        cpulse_ff <= 1'b0;
      end
      // Clear first: the last word's pulse flag still stands at a new command
      if (initial_clear) begin
        cpulse_seen_ff <= 1'b0;
      end else if (cpulse_ff) begin
        cpulse_seen_ff <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Control cycle on the drive bus
  // ----------------------------------------------------------------
  logic cyc_req_ff;
  logic cyc_req_d_ff;
  logic rbus_cyc_ff;
  logic cyc_act_ff;
  logic deskew_wait_ff;
  logic demand_ff;
  logic sync_ff;
  logic resp_err_ff;
  wire  cyc_act_fire;
  wire  deskew_fire;
  wire  timeout_fire;

  wire cycle_request_pulse = cyc_req_ff && !cyc_req_d_ff;
  wire cyc_act_set  = cyc_act_fire && !cyc_act_ff;
  wire deskew_go    = deskew_wait_ff && (!prev_cycle_read_i || !tra_in);
  wire demand_set   = deskew_fire && !tra_in && !sync_ff;
  wire tra_answer   = demand_ff && tra_in;
  wire end_cycle    = tra_answer && !attn_summary_addressed_i;

  // Request the cycle once the first channel pulse has been seen
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_req_ff   <= 1'b0;
      cyc_req_d_ff <= 1'b0;
      rbus_cyc_ff  <= 1'b0;
    end else begin
      cyc_req_d_ff <= cyc_req_ff;
      // Clear first, else a stale seen flag keeps the request stuck high
      if (initial_clear) begin
        cyc_req_ff <= 1'b0;
      end else if (cpulse_seen_ff && !maint_mode_i) begin
        cyc_req_ff <= 1'b1;
      end
      if (register_bus_cycle_req_i) begin
        rbus_cyc_ff <= 1'b1;
      end else if (cycle_request_pulse) begin
        rbus_cyc_ff <= 1'b0;
      end
    end
  end

  // 100 ns from the request pulse to cycle active
  pulse_delay #(.CYCLES(`CYC_MIN(`T_CYCACT_NS))) act_dly (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .start_i   (cycle_request_pulse),
    .cancel_i  (initial_clear),
    .run_o     (),
    .fire_o    (cyc_act_fire)
  );

  // 275 ns deskew lets address and control lines settle
  pulse_delay #(.CYCLES(`CYC_MIN(`T_DESKEW_NS))) dsk_dly (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .start_i   (deskew_go),
    .cancel_i  (initial_clear),
    .run_o     (),
    .fire_o    (deskew_fire)
  );

  // Longest wait rounds down so the error is never late
  pulse_delay #(.CYCLES(`CYC_MAX(`T_DEMAND_NS))) tmo_dly (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .start_i   (demand_set),
    .cancel_i  (tra_in || initial_clear),
    .run_o     (),
    .fire_o    (timeout_fire)
  );

  // Cycle active, deskew wait and demand
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_act_ff     <= 1'b0;
      deskew_wait_ff <= 1'b0;
      demand_ff      <= 1'b0;
    end else begin
      if (cyc_act_fire) begin
        cyc_act_ff <= 1'b1;
      end else if (end_cycle || initial_clear) begin
        cyc_act_ff <= 1'b0;
      end
      if (cyc_act_set) begin
        deskew_wait_ff <= 1'b1;
      end else if (deskew_go || initial_clear) begin
        deskew_wait_ff <= 1'b0;
      end
      if (demand_set) begin
        demand_ff <= 1'b1;
      end else if (end_cycle || initial_clear) begin
        demand_ff <= 1'b0;
      end
    end
  end

  // Sync blocks a transient re-demand; error is sticky until next command
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_ff     <= 1'b0;
      resp_err_ff <= 1'b0;
    end else begin
      if (tra_answer) begin
        sync_ff <= 1'b1;
      end else if (initial_clear) begin
        sync_ff <= 1'b0;
      end
      if (timeout_fire) begin
        resp_err_ff <= 1'b1;
      end else if (initial_clear) begin
        resp_err_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign chan_o.start_req    = req_active_ff || start_in;
  assign chan_o.grant_down   = grant_in && !req_active_ff;
  assign chan_o.device_pulse = dev_pulse;
  assign chan_o.data_strobe  = data_strobe_ff;
  assign chan_o.direction    = busy_ff && is_read;
  assign chan_o.bus          = chan_bus_ff;

  assign drive_o.demand       = demand_ff;
  assign drive_o.cycle_active = cyc_act_ff;
  assign drive_o.cycle_sync   = sync_ff;

  assign drive_choice_o            = drive_choice_ff;
  assign function_code_o           = function_code_register_ff;
  assign go_o                      = go_ff;
  assign initial_clear_pulse_o     = initial_clear;
  assign controller_busy_flag_o    = busy_ff;
  assign completion_flag_o         = done_ff;
  assign channel_buffer_full_o     = cb_full_ff;
  assign channel_pulse_seen_o      = cpulse_seen_ff;
  assign register_bus_cycle_flag_o = rbus_cyc_ff;
  assign drive_response_error_o    = resp_err_ff;

endmodule
`default_nettype wire

// File: tb/read_transfer_initiation_properties.sv
// Checker for the read transfer start-up block
`timescale 1ns/1ps
`default_nettype none
module read_transfer_initiation_properties (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic data_out_instruction_i,
  input wire logic [6:0] io_select_lines_i,
  input wire logic [35:0] io_data_bits_i,
  input wire logic transfer_complete_i,
  input wire logic attn_summary_addressed_i,
  input wire xfer_init_pkg::chan_out_s chan_o,
  input wire xfer_init_pkg::drive_out_s drive_o,
  input wire logic [2:0] drive_choice_o,
  input wire logic [4:0] function_code_o,
  input wire logic go_o,
  input wire logic initial_clear_pulse_o,
  input wire logic controller_busy_flag_o,
  input wire logic drive_response_error_o
);
  // One domain, so one clock and one disable for all
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  AST_CLEAR: assert property (initial_clear_pulse_o |-> transfer_complete_i &&
    $past(data_out_instruction_i) && $past(io_select_lines_i) == 7'h2e && $past(io_data_bits_i[35:32]) == 4'h8)
    else $error("load strobe without a valid command");
  AST_DRV: assert property (initial_clear_pulse_o |=> drive_choice_o == $past(io_data_bits_i[20:18], 2))
    else $error("drive choice not loaded");
  AST_FUNC: assert property (initial_clear_pulse_o |=> function_code_o == $past(io_data_bits_i[5:1], 2))
    else $error("function code not loaded");
  AST_GO: assert property ($rose(controller_busy_flag_o) |-> go_o && $past(initial_clear_pulse_o, 2))
    else $error("busy without go");
  AST_DEVPLS: assert property ($rose(chan_o.data_strobe) |-> ##9 chan_o.device_pulse)
    else $error("device pulse late or early");
  AST_DEMAND: assert property ($rose(drive_o.demand) |-> $past(drive_o.cycle_active, 28) && !drive_o.cycle_sync)
    else $error("demand before deskew");
  AST_TMO: assert property ($rose(drive_response_error_o) |-> $past(drive_o.demand, 140))
    else $error("response error without long demand");
  AST_END: assert property ($rose(drive_o.cycle_sync) && !attn_summary_addressed_i |->
    ##[0:2] !drive_o.demand && !drive_o.cycle_active) else $error("cycle not ended");
endmodule
bind read_transfer_initiation read_transfer_initiation_properties chk_u (.sys_clk_i, .rst_i,
  .data_out_instruction_i, .io_select_lines_i, .io_data_bits_i, .transfer_complete_i, .attn_summary_addressed_i,
  .chan_o, .drive_o, .drive_choice_o, .function_code_o, .go_o, .initial_clear_pulse_o, .controller_busy_flag_o,
  .drive_response_error_o);
`default_nettype wire

// File: tb/far_side_model.sv
// Far side model: channel controller and drive
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic down_i,
  input wire logic mute_i,
  input wire xfer_init_pkg::chan_out_s chan_o,
  input wire xfer_init_pkg::drive_out_s drive_o,
  output var xfer_init_pkg::chan_in_s chan_i,
  output var logic tra_o
);
  // Grant follows request; a word pulse answers each device pulse
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chan_i <= '0;
      tra_o <= 1'b0;
    end else begin
      chan_i.grant <= chan_o.start_req;
      chan_i.start_req <= down_i;
      chan_i.pulse <= chan_o.device_pulse;
      tra_o <= drive_o.demand & ~mute_i; // Mute drive never answers
    end
  end
endmodule
`default_nettype wire

// File: tb/read_transfer_initiation_tb.sv
// Testbench for the read transfer start-up block
`timescale 1ns/1ps
`default_nettype none
module read_transfer_initiation_tb;
  logic clk = 0, rst = 1, dout = 0, tc = 1, prior = 0, loc = 0, sw = 0, maint = 0, down = 0, mute = 0, transfer_ack_signal;
  logic rbreq = 0, prv = 0, attn = 0, boot = 0, cbf, rbf;
  logic [6:0] sel = 7'h2e;
  logic [35:0] dat = '0;
  int mismatches = 0, samples_checked = 0;
  xfer_init_pkg::chan_in_s ci;
  xfer_init_pkg::chan_out_s co;
  xfer_init_pkg::drive_out_s dr;
  logic [2:0] dc;
  logic [4:0] fc;
  logic go, busy, done, seen, err;
  always #5 clk = ~clk;
  read_transfer_initiation dut_u (.sys_clk_i(clk), .rst_i(rst), .data_out_instruction_i(dout),
    .io_select_lines_i(sel), .io_data_bits_i(dat), .transfer_complete_i(tc), .prior_start_pending_i(prior),
    .local_mode_i(loc), .bootstrap_read_mode_i(boot), .maint_mode_i(maint), .register_bus_cycle_req_i(rbreq),
    .prev_cycle_read_i(prv), .attn_summary_addressed_i(attn), .panel_channel_switch_i(sw), .chan_i(ci),
    .transfer_ack_signal_i(transfer_ack_signal), .chan_o(co), .drive_o(dr), .drive_choice_o(dc), .function_code_o(fc),
    .go_o(go), .initial_clear_pulse_o(), .controller_busy_flag_o(busy), .completion_flag_o(done),
    .channel_buffer_full_o(cbf), .channel_pulse_seen_o(seen), .register_bus_cycle_flag_o(rbf),
    .drive_response_error_o(err));
  far_side_model fs_u (.sys_clk_i(clk), .rst_i(rst), .down_i(down), .mute_i(mute), .chan_o(co),
    .drive_o(dr), .chan_i(ci), .tra_o(transfer_ack_signal));
  task automatic check(string n, logic [35:0] s, logic [35:0] e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", n, e, s);
    end
  endtask
  task automatic report_and_stop();
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Command word: select 40 octal, drive, address, function, go
  function automatic logic [35:0] mk(logic [2:0] d, logic [7:0] a, logic [4:0] f, logic g);
    return {4'h8, 11'h0, d, 3'h0, a, 1'b0, f, g};
  endfunction
  // Ends on a falling edge so that flags are settled
  task automatic cmd(logic [35:0] w, int n);
    @(posedge clk) dout <= 1'b1;
    dat <= w;
    @(posedge clk) dout <= 1'b0;
    repeat (n) @(negedge clk);
  endtask
  initial begin
    #100000;
    mismatches++;
    report_and_stop();
  end
  initial begin
    logic [7:0] a;
    logic [2:0] d;
    logic [4:0] f;
    void'($urandom(17427));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    sel <= 7'h2e ^ 7'(1 + $urandom % 127);
    cmd(mk(3'h5, 8'h5a, 5'h1c, 1'b1), 4);
    @(posedge clk) sel <= 7'h2e;
    cmd({4'h4, 32'h1}, 4);
    @(posedge clk) tc <= 1'b0;
    cmd(mk(3'h5, 8'h5a, 5'h1c, 1'b1), 4);
    @(posedge clk) tc <= 1'b1;
    check("go", go, 1'b0);
    repeat (6) begin
      {d, a, f} = 16'($urandom);
      cmd(mk(d, a, f, 1'b0), 4);
      check("drive", {dc, fc}, {d, f});
      check("busy", busy, 1'b0);
    end
    @(posedge clk) rbreq <= 1'b1;
    prv <= 1'b1;
    @(posedge clk) rbreq <= 1'b0;
    a = 8'($urandom);
    cmd(mk(3'h7, a, 5'h1c, 1'b1), 4);
    check("dir", {busy, co.direction, rbf}, 3'h7);
    for (int i = 0; i < 100 && !co.device_pulse; i++) @(negedge clk);
    check("addr", co.bus[8:1], a);
    for (int i = 0; i < 300 && !dr.cycle_sync; i++) @(negedge clk);
    check("cycle", {seen, dr.demand, err, cbf, rbf}, 5'h12);
    @(posedge clk) prior <= 1'b1;
    prv <= 1'b0;
    cmd(mk(3'h1, 8'h00, 5'h1c, 1'b1), 4);
    check("done", {done, busy}, 2'h2);
    @(posedge clk) prior <= 1'b0;
    loc <= 1'b1;
    cmd(mk(3'h3, 8'hff, 5'h1c, 1'b1), 20);
    check("local", co.start_req, 1'b0);
    @(posedge clk) sw <= 1'b1;
    mute <= 1'b1;
    cmd(mk(3'h3, 8'hff, 5'h1c, 1'b1), 300);
    check("tmo", {co.start_req, err}, 2'h3);
    @(posedge clk) mute <= 1'b0;
    down <= 1'b1;
    cmd(mk(3'h2, 8'h11, 5'h1c, 1'b1), 20);
    check("pass", {co.grant_down, seen}, 2'h2);
    @(posedge clk) down <= 1'b0;
    attn <= 1'b1;
    cmd(mk(3'h6, 8'h44, 5'h1c, 1'b1), 150);
    check("attn", {dr.cycle_sync, dr.demand, dr.cycle_active}, 3'h7);
    @(posedge clk) attn <= 1'b0;
    maint <= 1'b1;
    cmd(mk(3'h4, 8'h22, 5'h1c, 1'b1), 150);
    check("maint", dr.cycle_active, 1'b0);
    @(posedge clk) boot <= 1'b1;
    cmd(mk(3'h0, 8'h33, 5'h1c, 1'b1), 40);
    check("boot", {seen, co.bus[8:1]}, 9'h022);
    report_and_stop();
  end
endmodule
`default_nettype wire
